/* src/sld_driver.sv */
// Purpose: serial-in latch driver with eight low-side sink outputs
// Assumes: host pins are asynchronous to core_clk and are synchronised here
// Notes: clock edges on the pins are detected in the core clock domain
//
// How it works
// - eight shift stages feed eight storage bits
// - shift clock rise shifts data into stage0
// - latch clock rise copies shift into storage
// - storage reaches buffer only when clear high
// - clear low zeroes shift, storage and count registers, flushes the fifo and sets state to SLD_CLEARED
// - enable high forces all sink outputs off
// - enable low: outputs follow storage bits
// - output bit one sinks, zero is off
// - cascade output exposes shift register data
`timescale 1ns/1ps
module sld_driver
  import sld_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // host pins
  input wire logic shift_clock,
  input wire logic latch_clock,
  input wire logic clear_n,
  input wire logic output_enable_n,
  input wire logic shift_data_in,
  // outputs
  output logic cascade_out,
  output logic [7:0] sink_outputs,
  output logic latch_pending
);
  import sld_pkg::*;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  sld_pins_type raw_pins;
  sld_pins_type sync_a;
  sld_pins_type pins;
  sld_pins_type pins_d;
  assign raw_pins = '{shift_clock, latch_clock, clear_n, output_enable_n, shift_data_in};
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      sync_a <= '0;
      pins <= '0;
      pins_d <= '0;
    end else begin
      sync_a <= raw_pins;
      pins <= sync_a;
      pins_d <= pins;
    end
  end
  wire shift_rise = pins.shift_clock && !pins_d.shift_clock;
  wire latch_rise = pins.latch_clock && !pins_d.latch_clock;
  wire clear_active = !pins.clear_n;

  // ----------------------------------------
  // shift register
  // ----------------------------------------
  logic [STAGES-1:0] shift_reg;
  logic [STAGES-1:0] next_shift;
  assign next_shift = {shift_reg[STAGES-2:0], pins.shift_data_in};
  always_ff @(posedge core_clk) begin
    if (!rst_n || clear_active) shift_reg <= ZERO_BYTE;
    else if (shift_rise) shift_reg <= next_shift;
  end
  assign cascade_out = shift_reg[STAGES-1];

  // ----------------------------------------
  // latch fifo and storage register
  // ----------------------------------------
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [7:0] fifo_out_data;
  sld_word_type word_in;
  assign word_in.data = shift_reg;
  // storage accepts one word per cycle; a stall only occurs if drained slower
  wire drain_ready = pins.clear_n;
  sld_fifo #(
    .WIDTH(STAGES),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .flush(clear_active),
    .in_valid(latch_rise && !clear_active),
    .in_ready(fifo_in_ready),
    .in_data(word_in.data),
    .out_valid(fifo_out_valid),
    .out_ready(drain_ready),
    .out_data(fifo_out_data)
  );
  assign latch_pending = fifo_out_valid || !fifo_in_ready;

  logic [STAGES-1:0] storage_reg;
  always_ff @(posedge core_clk) begin
    if (!rst_n || clear_active) storage_reg <= ZERO_BYTE;
    else if (fifo_out_valid && drain_ready) storage_reg <= fifo_out_data;
  end

  // ----------------------------------------
  // shift count since clear
  // ----------------------------------------
  // counts shift edges up to eight; below eight the cascade tap still holds a cleared zero
  logic [3:0] shift_count;
  logic [3:0] next_count;
  wire count_full = (shift_count == LAST_CNT);
  assign next_count = count_full ? LAST_CNT : shift_count + 1'b1;
  always_ff @(posedge core_clk) begin
    if (!rst_n || clear_active) shift_count <= ZERO_CNT;
    else if (shift_rise) shift_count <= next_count;
  end

  // ----------------------------------------
  // sequencing state
  // ----------------------------------------
  // run: shift register holds bits not yet latched; idle: last latch copied it
  sld_state_type state;
  sld_state_type next_state;
  always_comb begin
    next_state = state;
    case (state)
      SLD_CLEARED: begin
        if (shift_rise) next_state = SLD_RUN;
        else if (latch_rise) next_state = SLD_IDLE;
      end
      SLD_IDLE: begin
        if (shift_rise) next_state = SLD_RUN;
      end
      SLD_RUN: begin
        if (latch_rise && !shift_rise) next_state = SLD_IDLE;
      end
      default: begin
        next_state = SLD_CLEARED;
      end
    endcase
    if (clear_active) next_state = SLD_CLEARED;
  end
  always_ff @(posedge core_clk) begin
    if (!rst_n) state <= SLD_CLEARED;
    else state <= next_state;
  end

  // ----------------------------------------
  // output buffer gating
  // ----------------------------------------
  wire pass_storage = pins.clear_n && !pins.output_enable_n;
  assign sink_outputs = pass_storage ? storage_reg : ZERO_BYTE;

  // ----------------------------------------
  // checks: output gating
  // ----------------------------------------
  a_gate_off: assert property (@(posedge core_clk) disable iff (!rst_n)
    pins.output_enable_n |-> sink_outputs == ZERO_BYTE)
    else $error("outputs on while enable high");
  a_gate_follow: assert property (@(posedge core_clk) disable iff (!rst_n)
    (!pins.output_enable_n && pins.clear_n) |-> sink_outputs == storage_reg)
    else $error("outputs do not follow storage");
  a_clear_block: assert property (@(posedge core_clk) disable iff (!rst_n)
    clear_active |-> sink_outputs == ZERO_BYTE)
    else $error("outputs on during clear");
  for (genvar b = 0; b < STAGES; b++) begin : g_sink_bit
    a_bit_off: assert property (@(posedge core_clk) disable iff (!rst_n)
      !storage_reg[b] |-> !sink_outputs[b])
      else $error("sink on for a zero storage bit");
  end

  // ----------------------------------------
  // checks: shift register and cascade
  // ----------------------------------------
  a_shift_step: assert property (@(posedge core_clk) disable iff (!rst_n)
    (shift_rise && !clear_active) |=> shift_reg == $past(next_shift))
    else $error("shift did not advance");
  a_shift_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
    (!shift_rise && !clear_active) |=> $stable(shift_reg))
    else $error("shift moved without edge");
  a_cascade_tap: assert property (@(posedge core_clk) disable iff (!rst_n)
    cascade_out == shift_reg[STAGES-1])
    else $error("cascade not last stage");
  a_cascade_step: assert property (@(posedge core_clk) disable iff (!rst_n)
    (shift_rise && !clear_active) |=> cascade_out == $past(shift_reg[STAGES-2]))
    else $error("cascade did not take the seventh stage");
  a_cascade_early: assert property (@(posedge core_clk) disable iff (!rst_n)
    (shift_count != LAST_CNT) |-> !cascade_out)
    else $error("cascade set before eight shifts");
  a_count_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
    (!shift_rise && !clear_active) |=> $stable(shift_count))
    else $error("shift count moved without edge");

  // ----------------------------------------
  // checks: latch, storage and clear
  // ----------------------------------------
  sequence s_latch_idle;
    latch_rise && !clear_active && !fifo_out_valid;
  endsequence
  sequence s_latch_taken;
    latch_rise && !clear_active && !latch_pending;
  endsequence
  sequence s_drain_once;
    latch_pending ##1 !latch_pending;
  endsequence
  a_latch_copy: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_latch_idle ##1 pins.clear_n [*2] |-> storage_reg == $past(shift_reg, 2))
    else $error("storage missed latch");
  a_latch_drain: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_latch_taken |=> s_drain_once)
    else $error("latched word not drained in one cycle");
  a_store_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
    (!fifo_out_valid && !clear_active) |=> $stable(storage_reg))
    else $error("storage moved without latch");
  a_idle_match: assert property (@(posedge core_clk) disable iff (!rst_n)
    (state == SLD_IDLE && !latch_pending && !clear_active) |-> storage_reg == shift_reg)
    else $error("storage differs from shift after latch");
  a_refuse_clear: assert property (@(posedge core_clk) disable iff (!rst_n)
    (latch_rise && clear_active) |=> !latch_pending)
    else $error("latch taken during clear");
  a_clear_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
    clear_active |=> shift_reg == ZERO_BYTE && storage_reg == ZERO_BYTE)
    else $error("clear left state");
  a_state_clear: assert property (@(posedge core_clk) disable iff (!rst_n)
    clear_active |=> state == SLD_CLEARED && shift_count == ZERO_CNT)
    else $error("clear left sequencing state");
endmodule // sld_driver

/* src/sld_pkg.sv */
// Purpose: shared constants and carrier types for the serial latch sink driver
// Assumes: one core clock at 125 MHz; pin inputs arrive asynchronously
// Notes: stage and fifo sizes and the zero reset constants live here
package sld_pkg;
  localparam int STAGES = 8;
  localparam int FIFO_DEPTH = 8;
  localparam int SYNC_LEN = 2;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [3:0] ZERO_CNT = 4'h0;
  localparam logic [3:0] LAST_CNT = 4'h8;
  // host pins, carried both before and after synchronisation
  typedef struct packed {
    logic shift_clock;
    logic latch_clock;
    logic clear_n;
    logic output_enable_n;
    logic shift_data_in;
  } sld_pins_type;
  // latch events pass the fifo with the byte they carry
  typedef struct packed {
    logic [7:0] data;
  } sld_word_type;
  typedef enum logic [1:0] {
    SLD_IDLE = 2'b00,
    SLD_RUN = 2'b01,
    SLD_CLEARED = 2'b11
  } sld_state_type;
endpackage

/* src/sld_fifo.sv */
// Purpose: small flip-flop fifo with valid/ready on both sides
// Assumes: single clock, synchronous active-low reset
// Notes: honest full and empty; flush empties it in one cycle
`timescale 1ns/1ps
module sld_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic flush,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  assign in_ready = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];
  always_ff @(posedge core_clk) begin
    if (!rst_n || flush) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) wr_ptr <= (32'(wr_ptr) == DEPTH - 1) ? '0 : wr_ptr + 1'b1;
      if (pop) rd_ptr <= (32'(rd_ptr) == DEPTH - 1) ? '0 : rd_ptr + 1'b1;
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
  always_ff @(posedge core_clk) begin
    if (push) mem[wr_ptr] <= in_data;
  end
endmodule // sld_fifo

/* tb/sld_host_model.sv */
// Purpose: host model driving the serial pins
// Assumes: each pin phase lasts 4 core cycles
// Notes: a released data pin shows the inverse of its last bit
`timescale 1ns/1ps
module sld_host_model (
  // clock
  input wire logic core_clk,
  // pins
  output logic shift_clock,
  output logic latch_clock,
  output logic clear_n,
  output logic output_enable_n,
  output logic shift_data_in
);
  initial begin
    {shift_clock, latch_clock, shift_data_in} = 3'h0;
    clear_n = 1'b0;
    output_enable_n = 1'b1;
  end
  task automatic hold4();
    repeat (4) @(posedge core_clk);
    #1;
  endtask
  task automatic set_pins(input logic clr_n, input logic oe_n);
    clear_n = clr_n;
    output_enable_n = oe_n;
  endtask
  // shifting only while latch_clock is low; msb goes first
  task automatic shift_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      shift_data_in = b[i];
      hold4();
      shift_clock = 1'b1;
      hold4();
      shift_clock = 1'b0;
      shift_data_in = ~b[i];
      hold4();
    end
  endtask
  task automatic latch();
    latch_clock = 1'b1;
    hold4();
    latch_clock = 1'b0;
    hold4();
  endtask
endmodule // sld_host_model

/* tb/tb_sld_driver.sv */
// Purpose: self-checking bench for the sink driver
// Assumes: 125 MHz core clock, pins from the host model
// Notes: table rows first, then clear, dimming and reset
`timescale 1ns/1ps
module tb_sld_driver;
  import sld_pkg::*;
  typedef struct packed {
    logic [7:0] data;
    logic oe_n;
    logic [7:0] sink;
  } sld_row_type;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic shift_clock, latch_clock, clear_n, output_enable_n, shift_data_in;
  logic cascade_out, latch_pending;
  logic [7:0] sink_outputs;
  int n_errors = 0;
  int n_compared = 0;
  int cycles = 0;
  sld_row_type rows [4] = '{'{8'ha5, 1'b0, 8'ha5}, '{8'h3c, 1'b1, 8'h00},
                            '{8'hff, 1'b0, 8'hff}, '{8'h81, 1'b0, 8'h81}};
  always #4 core_clk = ~core_clk;
  sld_host_model host (.core_clk(core_clk), .shift_clock(shift_clock),
    .latch_clock(latch_clock), .clear_n(clear_n),
    .output_enable_n(output_enable_n), .shift_data_in(shift_data_in));
  sld_driver DUT (.core_clk(core_clk), .rst_n(rst_n), .shift_clock(shift_clock),
    .latch_clock(latch_clock), .clear_n(clear_n), .output_enable_n(output_enable_n),
    .shift_data_in(shift_data_in), .cascade_out(cascade_out),
    .sink_outputs(sink_outputs), .latch_pending(latch_pending));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_errors++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (20) @(posedge core_clk);
    #1;
    rst_n = 1'b1;
    host.hold4();
    host.set_pins(1'b1, 1'b0);
    foreach (rows[i]) begin
      host.shift_byte(rows[i].data);
      check({7'h0, cascade_out}, {7'h0, rows[i].data[7]});
      host.latch();
      check({7'h0, latch_pending}, 8'h00);
      host.set_pins(1'b1, rows[i].oe_n);
      host.hold4();
      check(sink_outputs, rows[i].sink);
      $display("row %0d done", i);
    end
    host.set_pins(1'b0, 1'b0);
    host.latch();
    check(sink_outputs, 8'h00);
    check({7'h0, cascade_out}, 8'h00);
    host.set_pins(1'b1, 1'b0);
    host.latch();
    check(sink_outputs, 8'h00);
    $display("clear test done");
    host.shift_byte(8'h5a);
    host.latch_clock = 1'b1;
    repeat (3) @(posedge core_clk);
    #1;
    check({7'h0, latch_pending}, 8'h01);
    check(sink_outputs, 8'h00);
    @(posedge core_clk);
    #1;
    check({7'h0, latch_pending}, 8'h00);
    check(sink_outputs, 8'h5a);
    host.latch_clock = 1'b0;
    host.hold4();
    host.set_pins(1'b1, 1'b1);
    host.hold4();
    check(sink_outputs, 8'h00);
    host.set_pins(1'b1, 1'b0);
    host.hold4();
    check(sink_outputs, 8'h5a);
    $display("dimming test done");
    rst_n = 1'b0;
    host.hold4();
    check(sink_outputs, 8'h00);
    check({7'h0, latch_pending}, 8'h00);
    $display("reset test done");
    rst_n = 1'b1;
    host.hold4();
    host.shift_byte(8'h96);
    check({7'h0, cascade_out}, 8'h01);
    host.latch();
    check(sink_outputs, 8'h96);
    $display("recovery test done");
    tally_and_finish();
  end
endmodule // tb_sld_driver
